//--- common/swc_defs.svh
/*
 * Constants of the sleep and wake controller: register indices, field
 * positions, reset values, codes and cycle counts.
 * Assumes it is included by its bare name wherever a number is needed.
 */
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH

`define SWC_IDX_MODE     6'h00
`define SWC_IDX_REGU     6'h01
`define SWC_IDX_GUARD    6'h02
`define SWC_IDX_STATUS   6'h03

`define SWC_SEN_BIT      0
`define SWC_SLEEP_MODE_SELECT_LSB    1
`define SWC_SLEEP_MODE_SELECT_MSB    3
`define SWC_HTL_BIT      4
`define SWC_REGULATOR_DRIVE_SELECT_LSB    0
`define SWC_REGULATOR_DRIVE_SELECT_MSB    2

`define SWC_MODE_RST     4'h0
`define SWC_REGULATOR_DRIVE_SELECT_RST    3'h0
`define SWC_HTL_RST      1'b0

`define SWC_SLEEP_MODE_SELECT_IDLE   3'h0
`define SWC_SLEEP_MODE_SELECT_STBY   3'h1
`define SWC_SLEEP_MODE_SELECT_PDN    3'h2
`define SWC_REGULATOR_DRIVE_SELECT_AUTO   3'h0
`define SWC_REGULATOR_DRIVE_SELECT_FULL   3'h1

`define SWC_BASE_CYC     16'h0006
`define SWC_GUARD_WIN    3'h4
`define SWC_BOD_WAITMODE 2'h3
`define SWC_FILT_ASYNC   2'h0
`define SWC_EDGE_ASYNC   1'b0

`endif

//--- common/swc_pkg.sv
/*
 * Types of the sleep and wake controller: controller states, latched
 * sleep mode, pending interrupt bundle and peripheral qualifiers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package swc_pkg;

	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_SLEEP  = 2'b01,
		ST_WAKE   = 2'b10,
		ST_BODW   = 2'b11
	} swc_state_e;

	typedef enum logic [1:0] {
		MD_IDLE = 2'b00,
		MD_STBY = 2'b01,
		MD_PDN  = 2'b10
	} swc_mode_e;

	// one bit per source, high while an enabled request is pending
	typedef struct packed {
		logic pin;
		logic voltage_level_monitor;
		logic multi_voltage_io;
		logic rtc_cnt;
		logic periodic_wake_timer;
		logic twi_match;
		logic custom_logic_unit;
		logic usart_sof;
		logic timer_type_a;
		logic tcb;
		logic adc;
		logic ac;
		logic zero_cross_detector;
		logic other;
	} swc_irq_s;

	typedef struct packed {
		logic       rtc_run_stdby;
		logic       adc_run_stdby;
		logic [1:0] lookup_filter_select;
		logic       lookup_edge_detect;
	} swc_qual_s;

endpackage

//--- rtl/swc_sleep_wake.sv
/*
 * Sleep and wake controller with an APB register slave. Takes the core
 * into idle, standby or deep power-off on a sleep request, filters wake
 * sources per mode, times the wake delay and can hold for brown-out ready.
 * Assumes all inputs come from logic on CLK; the fuse level of the
 * brown-out mode is static while the core runs.
 */
`timescale 1ns/1ps
`include "swc_defs.svh"

// Behaviour
// - idle: any enabled interrupt but usart_sof wakes the core
// - standby peripheral wake needs its run_in_standby
// - deep power-off: only periodic_wake_timer of counter
// - custom_logic_unit wakes deep power-off only asynchronous
// - hot_leak_reduce blocks two-wire match, custom_logic_unit
// - USART start-of-frame standby only; timer_type_a, tcb idle only
// - idle wake takes six peripheral_clock cycles
// - deeper modes add oscillator, regulator start-up
// - deep power-off keeps only slow clocks if needed
// - brown-out mode 0x3 waits for detector ready
// - wake delay is longer of both times
// - runs normally while debugger attached
// - debug break wakes core without interrupt
// - unguarded write to regulator_control is ignored
// - sleep_mode_select codes idle, standby, deep power-off
// - sleep entered only with sleep_enable_bit set
// - hot_leak_reduce acts only with automatic drive
// - regulator_drive_select automatic or full drive
module swc_sleep_wake #(
	parameter logic [15:0] OSC_START_CYC = 16'h0010,
	parameter logic [15:0] REG_START_CYC = 16'h0008,
	parameter logic [7:0]  GUARD_KEY     = 8'hA5  // arbitrary key value
) (
	// clock and reset
	input  wire logic               CLK,
	input  wire logic               RESET,
	// apb slave
	input  wire logic               PSEL,
	input  wire logic               PENABLE,
	input  wire logic               PWRITE,
	input  wire logic [7:0]         PADDR,
	input  wire logic [31:0]        PWDATA,
	input  wire logic [3:0]         PSTRB,
	output logic [31:0]             PRDATA,
	output logic                    PREADY,
	output logic                    PSLVERR,
	// processor core
	input  wire logic               SLEEP_EXEC,
	input  wire logic               INSTR_RETIRE,
	input  wire logic               DEBUG_BREAK,
	output logic                    CORE_RUN,
	output logic                    SLEEPING,
	// interrupt sources and their settings
	input  wire swc_pkg::swc_irq_s  IRQ_PEND,
	input  wire swc_pkg::swc_qual_s IRQ_QUAL,
	// clock, regulator and brown-out status
	input  wire logic               MAIN_CLK_STDBY,
	input  wire logic               SLOW_CLK_NEEDED,
	input  wire logic               SLOW_OSC_SELECTED,
	input  wire logic [1:0]         BOD_ACTIVE_MODE,
	input  wire logic               BOD_READY,
	// power controls
	output logic                    MAIN_CLK_EN,
	output logic                    SLOW_CLK_EN,
	output logic                    REG_LOW_POWER,
	output logic                    HOT_LEAK_EN
);

	swc_pkg::swc_state_e state_r;
	swc_pkg::swc_state_e state_nxt;
	swc_pkg::swc_mode_e  mode_r;
	swc_pkg::swc_mode_e  mode_sel;

	logic [3:0]  mode_ctl_r;
	logic [2:0]  regulator_drive_select_r;
	logic        htl_r;
	logic [2:0]  guard_win_r;
	logic [15:0] wake_cnt_r;
	logic [15:0] wake_cnt_nxt;

	// apb decode
	wire [5:0] reg_idx    = PADDR[7:2];
	wire       aligned    = (PADDR[1:0] == 2'b00);
	wire       hit_mode   = aligned && (reg_idx == `SWC_IDX_MODE);
	wire       hit_regu   = aligned && (reg_idx == `SWC_IDX_REGU);
	wire       hit_guard  = aligned && (reg_idx == `SWC_IDX_GUARD);
	wire       hit_status = aligned && (reg_idx == `SWC_IDX_STATUS);
	wire       mapped     = hit_mode || hit_regu || hit_guard || hit_status;
	wire       access     = PSEL && PENABLE;
	wire       xfer_done  = access && PREADY;
	wire       wr_lane0   = xfer_done && PWRITE && PSTRB[0] && mapped;

	wire       wr_mode    = wr_lane0 && hit_mode;
	wire       wr_guard   = wr_lane0 && hit_guard;
	wire       guard_open = (guard_win_r != 3'h0);
	wire       key_ok     = (PWDATA[7:0] == GUARD_KEY);
	wire       wr_regu    = wr_lane0 && hit_regu && guard_open;

	// register fields
	wire       sleep_en   = mode_ctl_r[`SWC_SEN_BIT];
	wire [2:0] sleep_mode_select      = mode_ctl_r[`SWC_SLEEP_MODE_SELECT_MSB:`SWC_SLEEP_MODE_SELECT_LSB];
	wire       drive_auto = (regulator_drive_select_r == `SWC_REGULATOR_DRIVE_SELECT_AUTO);
	// leakage reduction only counts with automatic drive and power-off
	wire       htl_eff    = htl_r && drive_auto;

	// reserved codes fall back to idle so no undefined state is reached
	always_comb begin
		unique case (sleep_mode_select)
			`SWC_SLEEP_MODE_SELECT_STBY: mode_sel = swc_pkg::MD_STBY;
			`SWC_SLEEP_MODE_SELECT_PDN:  mode_sel = swc_pkg::MD_PDN;
			default:         mode_sel = swc_pkg::MD_IDLE;
		endcase
	end

	// wake source filtering per latched mode
	wire in_idle = (mode_r == swc_pkg::MD_IDLE);
	wire in_stby = (mode_r == swc_pkg::MD_STBY);
	wire in_pdn  = (mode_r == swc_pkg::MD_PDN);

	wire ccl_async = (IRQ_QUAL.lookup_filter_select == `SWC_FILT_ASYNC) &&
		(IRQ_QUAL.lookup_edge_detect == `SWC_EDGE_ASYNC);

	wire wake_idle = IRQ_PEND.pin || IRQ_PEND.voltage_level_monitor || IRQ_PEND.multi_voltage_io ||
		IRQ_PEND.rtc_cnt || IRQ_PEND.periodic_wake_timer || IRQ_PEND.twi_match ||
		IRQ_PEND.custom_logic_unit || IRQ_PEND.timer_type_a || IRQ_PEND.tcb ||
		IRQ_PEND.adc || IRQ_PEND.ac || IRQ_PEND.zero_cross_detector ||
		IRQ_PEND.other;

	wire wake_stby = IRQ_PEND.pin || IRQ_PEND.voltage_level_monitor || IRQ_PEND.multi_voltage_io ||
		(IRQ_PEND.rtc_cnt && IRQ_QUAL.rtc_run_stdby) ||
		IRQ_PEND.periodic_wake_timer ||
		(IRQ_PEND.adc && IRQ_QUAL.adc_run_stdby) ||
		IRQ_PEND.twi_match || IRQ_PEND.custom_logic_unit ||
		IRQ_PEND.usart_sof;

	wire wake_pdn = IRQ_PEND.pin || IRQ_PEND.voltage_level_monitor || IRQ_PEND.multi_voltage_io ||
		IRQ_PEND.periodic_wake_timer ||
		(IRQ_PEND.twi_match && !htl_eff) ||
		(IRQ_PEND.custom_logic_unit && ccl_async && !htl_eff);

	wire wake_hit = (in_idle && wake_idle) || (in_stby && wake_stby) ||
		(in_pdn && wake_pdn);

	// the wake delay grows by each start-up that the sleep made necessary
	wire osc_stopped = in_pdn || (in_stby && !MAIN_CLK_STDBY);
	wire reg_stopped = !in_idle && drive_auto;
	wire [15:0] osc_add = osc_stopped ? OSC_START_CYC : 16'h0000;
	wire [15:0] reg_add = reg_stopped ? REG_START_CYC : 16'h0000;
	wire [15:0] wake_load = `SWC_BASE_CYC + osc_add + reg_add;

	wire bod_wait = (BOD_ACTIVE_MODE == `SWC_BOD_WAITMODE);
	wire cnt_last = (wake_cnt_r == 16'h0001);

	// debug activity only matters while asleep; awake it changes nothing
	always_comb begin
		state_nxt    = state_r;
		wake_cnt_nxt = wake_cnt_r;
		unique case (state_r)
			swc_pkg::ST_ACTIVE: begin
				if (SLEEP_EXEC && sleep_en) begin
					state_nxt = swc_pkg::ST_SLEEP;
				end
			end
			swc_pkg::ST_SLEEP: begin
				if (wake_hit || DEBUG_BREAK) begin
					state_nxt    = swc_pkg::ST_WAKE;
					wake_cnt_nxt = wake_load;
				end
			end
			swc_pkg::ST_WAKE: begin
				if (cnt_last) begin
					// the longer of count and detector ready wins
					if (bod_wait && !BOD_READY) begin
						state_nxt = swc_pkg::ST_BODW;
					end else begin
						state_nxt = swc_pkg::ST_ACTIVE;
					end
				end else begin
					wake_cnt_nxt = wake_cnt_r - 16'h0001;
				end
			end
			swc_pkg::ST_BODW: begin
				if (BOD_READY) begin
					state_nxt = swc_pkg::ST_ACTIVE;
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_r    <= swc_pkg::ST_ACTIVE;
			wake_cnt_r <= 16'h0000;
		end else begin
			state_r    <= state_nxt;
			wake_cnt_r <= wake_cnt_nxt;
		end
	end

	// mode is frozen at sleep entry so register writes cannot move it
	always_ff @(posedge CLK) begin
		if (RESET) begin
			mode_r <= swc_pkg::MD_IDLE;
		end else if (state_r == swc_pkg::ST_ACTIVE &&
				state_nxt == swc_pkg::ST_SLEEP) begin
			mode_r <= mode_sel;
		end
	end

	// control registers
	always_ff @(posedge CLK) begin
		if (RESET) begin
			mode_ctl_r <= `SWC_MODE_RST;
		end else if (wr_mode) begin
			mode_ctl_r <= PWDATA[3:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			regulator_drive_select_r <= `SWC_REGULATOR_DRIVE_SELECT_RST;
			htl_r   <= `SWC_HTL_RST;
		end else if (wr_regu) begin
			regulator_drive_select_r <= PWDATA[`SWC_REGULATOR_DRIVE_SELECT_MSB:`SWC_REGULATOR_DRIVE_SELECT_LSB];
			htl_r   <= PWDATA[`SWC_HTL_BIT];
		end
	end

	// unlock window: opened by the key, shut by the guarded write or by
	// the fourth retired instruction; a fresh key write wins over both
	always_ff @(posedge CLK) begin
		if (RESET) begin
			guard_win_r <= 3'h0;
		end else if (wr_guard && key_ok) begin
			guard_win_r <= `SWC_GUARD_WIN;
		end else if (wr_regu) begin
			guard_win_r <= 3'h0;
		end else if (INSTR_RETIRE && guard_open) begin
			guard_win_r <= guard_win_r - 3'h1;
		end
	end

	// read mux; reserved bits read zero, the key register reads zero
	wire [31:0] rd_mode   = {27'h0, mode_ctl_r};
	wire [31:0] rd_regu   = {27'h0, htl_r, 1'b0, regulator_drive_select_r};
	wire [31:0] rd_status = {26'h0, CORE_RUN, guard_open, mode_r, state_r};
	wire [31:0] rd_data   = hit_mode   ? rd_mode :
		hit_regu   ? rd_regu :
		hit_status ? rd_status : 32'h0000_0000;

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge CLK) begin
		if (RESET) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else if (access && !PREADY) begin
			PREADY  <= 1'b1;
			PRDATA  <= PWRITE ? 32'h0000_0000 : rd_data;
			PSLVERR <= !mapped;
		end else begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
	end

	// power outputs follow the next state so they change with it
	swc_pkg::swc_mode_e mode_nxt_sel;
	assign mode_nxt_sel = (state_r == swc_pkg::ST_ACTIVE) ? mode_sel : mode_r;
	wire nxt_sleep = (state_nxt == swc_pkg::ST_SLEEP);
	wire nxt_idle  = (mode_nxt_sel == swc_pkg::MD_IDLE);
	wire nxt_stby  = (mode_nxt_sel == swc_pkg::MD_STBY);
	wire nxt_pdn   = (mode_nxt_sel == swc_pkg::MD_PDN);

	wire main_on = !nxt_sleep || nxt_idle ||
		(nxt_stby && MAIN_CLK_STDBY);
	wire slow_on = !nxt_sleep || !nxt_pdn || SLOW_CLK_NEEDED;
	// automatic drive saves power asleep below idle, or on slow osc
	wire low_pwr = drive_auto &&
		((nxt_sleep && !nxt_idle) || SLOW_OSC_SELECTED);
	wire leak_on = nxt_sleep && nxt_pdn && htl_eff;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			CORE_RUN      <= 1'b1;
			SLEEPING      <= 1'b0;
			MAIN_CLK_EN   <= 1'b1;
			SLOW_CLK_EN   <= 1'b1;
			REG_LOW_POWER <= 1'b0;
			HOT_LEAK_EN   <= 1'b0;
		end else begin
			CORE_RUN      <= (state_nxt == swc_pkg::ST_ACTIVE);
			SLEEPING      <= nxt_sleep;
			MAIN_CLK_EN   <= main_on;
			SLOW_CLK_EN   <= slow_on;
			REG_LOW_POWER <= low_pwr;
			HOT_LEAK_EN   <= leak_on;
		end
	end

endmodule

//--- tb/swc_sleep_wake_asserts.sv
/* port checker of the sleep and wake controller.
   assumes a bind from the bench top file, one clock domain. */
`timescale 1ns/1ps
module swc_sleep_wake_asserts (
	// clock and reset
	input wire logic              CLK,
	input wire logic              RESET,
	// core side
	input wire logic              SLEEP_EXEC,
	input wire logic              DEBUG_BREAK,
	input wire logic              CORE_RUN,
	input wire logic              SLEEPING,
	// sources and power
	input wire swc_pkg::swc_irq_s IRQ_PEND,
	input wire logic              SLOW_CLK_NEEDED,
	input wire logic [1:0]        BOD_ACTIVE_MODE,
	input wire logic              BOD_READY,
	input wire logic              MAIN_CLK_EN,
	input wire logic              SLOW_CLK_EN,
	input wire logic              HOT_LEAK_EN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// any source that might wake standby or power-off
	wire deep_ok = (IRQ_PEND & 14'h3FC8) != 14'h0000;
	property p_entry;
		$rose(SLEEPING) |-> $past(SLEEP_EXEC) && !CORE_RUN;
	endproperty
	a_entry: assert property (p_entry) else $error("bad entry");
	property p_min;
		$fell(SLEEPING) && !CORE_RUN |-> !CORE_RUN [*6];
	endproperty
	a_min: assert property (p_min) else $error("wake early");
	property p_max;
		$fell(SLEEPING) && BOD_ACTIVE_MODE != 2'h3 |-> ##[1:40] CORE_RUN;
	endproperty
	a_max: assert property (p_max) else $error("wake late");
	property p_bod;
		BOD_ACTIVE_MODE == 2'h3 && !BOD_READY && !CORE_RUN && !SLEEPING
			|=> !CORE_RUN;
	endproperty
	a_bod: assert property (p_bod) else $error("bod skipped");
	property p_hold;
		CORE_RUN && !SLEEP_EXEC |=> CORE_RUN;
	endproperty
	a_hold: assert property (p_hold) else $error("core dropped");
	property p_dbg;
		SLEEPING && DEBUG_BREAK |=> !SLEEPING;
	endproperty
	a_dbg: assert property (p_dbg) else $error("no debug wake");
	property p_deep;
		SLEEPING && !MAIN_CLK_EN && !DEBUG_BREAK && !deep_ok |=> SLEEPING;
	endproperty
	a_deep: assert property (p_deep) else $error("bad source");
	property p_slow;
		SLEEPING && SLOW_CLK_NEEDED |-> SLOW_CLK_EN;
	endproperty
	a_slow: assert property (p_slow) else $error("slow clk off");
	property p_awake;
		!SLEEPING |-> MAIN_CLK_EN && !HOT_LEAK_EN;
	endproperty
	a_awake: assert property (p_awake) else $error("awake power");
	c_sleep: cover property ($rose(SLEEPING));
	c_dbg: cover property (SLEEPING && DEBUG_BREAK);
	c_htl: cover property (HOT_LEAK_EN);
endmodule

//--- tb/swc_core_model.sv
/* core model: issues the sleep instruction and retires instructions.
   assumes the bench asks by level on go and retire. */
`timescale 1ns/1ps
module swc_core_model (
	// clock
	input  wire logic CLK,
	// bench requests
	input  wire logic go,
	input  wire logic retire,
	// core lines
	input  wire logic core_run,
	output logic      sleep_exec,
	output logic      instr_retire
);
	initial sleep_exec = 1'b0;
	initial instr_retire = 1'b0;
	// a halted core neither sleeps nor retires
	always @(posedge CLK) begin
		sleep_exec <= go && core_run;
		instr_retire <= retire && core_run;
	end
endmodule

//--- tb/swc_sleep_wake_test.sv
/* bench of the sleep and wake controller: registers, guard, sleep
   and wake in each mode, debug break and brown-out wait.
   assumes the package, design, core model and checker files. */
`timescale 1ns/1ps
module swc_sleep_wake_test;
	localparam logic [7:0] KEY = 8'h5C; // arbitrary key value
	logic              CLK, RESET, PSEL, PENABLE, PWRITE;
	logic              DEBUG_BREAK, BOD_READY, go, ret;
	logic [7:0]        PADDR;
	logic [31:0]       PWDATA, PRDATA;
	logic [1:0]        BOD_ACTIVE_MODE;
	logic              PREADY, PSLVERR, SLEEP_EXEC, INSTR_RETIRE;
	logic              CORE_RUN, SLEEPING, MAIN_CLK_EN, SLOW_CLK_EN;
	logic              REG_LOW_POWER, HOT_LEAK_EN;
	swc_pkg::swc_irq_s IRQ_PEND;
	swc_pkg::swc_qual_s IRQ_QUAL;
	logic              SLOW_CLK_NEEDED;
	logic [32:0]       rq[$];
	int                wq[$];
	int                miscompares, n_tests, cnt;
	logic              psl = 1'b0;
	logic              prn = 1'b1;
	swc_sleep_wake #(.OSC_START_CYC(16'h0004),
		.REG_START_CYC(16'h0003), .GUARD_KEY(KEY))
	swc_sleep_wake_inst (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PSTRB(4'hF), .PRDATA, .PREADY, .PSLVERR, .SLEEP_EXEC,
		.INSTR_RETIRE, .DEBUG_BREAK, .CORE_RUN, .SLEEPING, .IRQ_PEND,
		.IRQ_QUAL, .MAIN_CLK_STDBY(1'b0), .SLOW_CLK_NEEDED,
		.SLOW_OSC_SELECTED(1'b0), .BOD_ACTIVE_MODE, .BOD_READY,
		.MAIN_CLK_EN, .SLOW_CLK_EN, .REG_LOW_POWER, .HOT_LEAK_EN);
	swc_core_model swc_core_model_inst (.CLK, .go, .retire(ret),
		.core_run(CORE_RUN), .sleep_exec(SLEEP_EXEC),
		.instr_retire(INSTR_RETIRE));
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [32:0] e, input logic [32:0] a);
		n_tests++;
		if (e !== a) begin
			miscompares++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	// one idle cycle after each transfer keeps psel single-driven
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {24'($urandom()), d};
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (!PREADY);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 8'h00);
	endtask
	task automatic nap(input logic [2:0] m, input logic [7:0] rg,
		input logic [13:0] blk, input logic [13:0] wk, input int n,
		input logic dbg);
		apb(1'b1, 8'h08, KEY);
		apb(1'b1, 8'h04, rg);
		apb(1'b1, 8'h00, {4'h0, m, 1'b1});
		wq.push_back(n);
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
		IRQ_PEND <= blk;
		SLOW_CLK_NEEDED <= 1'($urandom());
		repeat (8) @(posedge CLK);
		chk(1, SLEEPING);
		chk(rg[4] && rg[2:0] == 3'h0 && m == 3'h2, HOT_LEAK_EN);
		chk(rg[2:0] == 3'h0 && m inside {1, 2}, REG_LOW_POWER);
		IRQ_PEND <= wk;
		DEBUG_BREAK <= dbg;
		@(posedge CLK);
		DEBUG_BREAK <= 1'b0;
		repeat (13) @(posedge CLK);
		BOD_READY <= 1'b1;
		repeat (8) @(posedge CLK);
		IRQ_PEND <= '0;
		$display("sleep test done");
	endtask
	// wake latency counted from the edge where sleeping falls
	always @(posedge CLK) begin
		#1;
		cnt++;
		if (psl && !SLEEPING)
			cnt = 0;
		if (!prn && CORE_RUN && !RESET)
			chk(wq.pop_front(), cnt);
		if (PREADY && !PWRITE)
			chk(rq.pop_front(), {PSLVERR, PRDATA});
		psl = SLEEPING;
		prn = CORE_RUN;
	end
	initial begin
		#500000;
		miscompares++;
		finish_test();
	end
	initial begin
		{PSEL, PENABLE, PWRITE, DEBUG_BREAK, go, ret} = '0;
		PADDR = '0;
		PWDATA = '0;
		IRQ_PEND = '0;
		IRQ_QUAL = '0;
		SLOW_CLK_NEEDED = 1'b1;
		BOD_ACTIVE_MODE = 2'h0;
		BOD_READY = 1'b1;
		RESET = 1'b1;
		void'($urandom(32'hE531A4A8));
		repeat (4) @(posedge CLK);
		RESET <= 1'b0;
		@(posedge CLK);
		rd(8'h00, 33'h0);
		apb(1'b1, 8'h04, 8'h11);
		rd(8'h04, 33'h0);
		apb(1'b1, 8'h08, KEY);
		ret <= 1'b1;
		repeat (6) @(posedge CLK);
		ret <= 1'b0;
		apb(1'b1, 8'h04, 8'h11);
		rd(8'h04, 33'h0);
		apb(1'b1, 8'h08, KEY);
		apb(1'b1, 8'h04, 8'h11);
		rd(8'h04, 33'h11);
		rd(8'h20, 33'h100000000);
		rd(8'h01, 33'h100000000);
		apb(1'b1, 8'h00, 8'h04);
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
		repeat (4) @(posedge CLK);
		chk(0, SLEEPING);
		rd(8'h00, 33'h04);
		$display("register test done");
		nap(3'h0, 8'h00, 14'h0040,
			(14'($urandom()) & 14'h3FBF) | 14'h0001, 6, 1'b0);
		nap(3'h1, 8'h00, 14'h0020, 14'h0040, 13, 1'b0);
		nap(3'h2, 8'h01, 14'h0400, 14'h0200, 10, 1'b0);
		nap(3'h2, 8'h10, 14'h0180, 14'h2000, 13, 1'b0);
		nap(3'h5, 8'h00, 14'h0040, 14'h0001, 6, 1'b0);
		nap(3'h1, 8'h00, 14'h0000, 14'h0000, 13, 1'b1);
		BOD_ACTIVE_MODE <= 2'h3;
		BOD_READY <= 1'b0;
		nap(3'h0, 8'h00, 14'h0000, 14'h0001, 14, 1'b0);
		finish_test();
	end
endmodule
bind swc_sleep_wake swc_sleep_wake_asserts chk_inst (.CLK, .RESET,
	.SLEEP_EXEC, .DEBUG_BREAK, .CORE_RUN, .SLEEPING, .IRQ_PEND,
	.SLOW_CLK_NEEDED, .BOD_ACTIVE_MODE, .BOD_READY, .MAIN_CLK_EN,
	.SLOW_CLK_EN, .HOT_LEAK_EN);
